/* File: smt_converge.sv */
// First-order lag that snaps to its input on load and creeps toward it per step
`timescale 1ns/1ps
module smt_converge #(
  parameter int SHIFT = 4
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  input  wire logic              load,
  input  wire logic              step,
  input  wire logic signed [7:0] target,
  output logic signed [7:0]      value
);
  import smt_pkg::*;

  typedef struct packed {
    logic signed [15:0] acc;
  } smt_lag_type;

  smt_lag_type        s_r;
  smt_lag_type        s_nxt;
  logic signed [16:0] diff;

  always_comb begin
    s_nxt = s_r;
    diff  = 17'($signed({target, 8'h00})) - 17'(s_r.acc);
    if (load) begin
      s_nxt.acc = {target, 8'h00};
    end else if (step) begin
      // Truncating shift stalls a fraction short on a rising input, so value reads one degree low; a falling input settles
      s_nxt.acc = 16'(s_r.acc + 16'(diff >>> SHIFT));
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign value = s_r.acc[15:8];
endmodule

/* File: smt_pkg.sv */
// Constants, register map and types for the service test and stroke limit block
package smt_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [7:0] ADDR_CONFIG  = 8'h00;
  localparam logic [7:0] ADDR_STROKE  = 8'h04;
  localparam logic [7:0] ADDR_SIM     = 8'h08;
  localparam logic [7:0] ADDR_RELAY   = 8'h0c;
  localparam logic [7:0] ADDR_CURVE   = 8'h10;
  localparam logic [7:0] ADDR_STATUS  = 8'h14;
  localparam logic [7:0] ADDR_TEMPS   = 8'h18;
  localparam logic [7:0] ADDR_SETPT   = 8'h1c;

  // ==========================================================================
  // Field positions and reset values
  localparam int         SIM_BLANK_BIT    = 8;
  localparam logic [7:0] CLOSE_MIN_RST    = 8'h06;
  localparam logic [7:0] CURVE_BASE_RST   = 8'h1e;
  localparam logic [7:0] CURVE_SLOPE_RST  = 8'h0c;
  localparam logic [2:0] RELAY_CODE_RST   = 3'h0;

  // ==========================================================================
  // Temperatures, signed whole degrees
  localparam logic signed [7:0] SIM_LOW     = -8'sd50;
  localparam logic signed [7:0] SIM_HIGH    = 8'sd50;
  localparam logic signed [7:0] CURVE_REF   = 8'sd20;
  localparam logic signed [7:0] WARM_POINT  = 8'sd15;
  localparam logic signed [7:0] COLD_POINT  = -8'sd5;
  localparam logic [5:0]        WARM_DELTA  = 6'(CURVE_REF - WARM_POINT);
  localparam logic [5:0]        COLD_DELTA  = 6'(CURVE_REF - COLD_POINT);
  localparam int                SLOPE_FRAC  = 3;

  // ==========================================================================
  // Timing in seconds of the system tick
  localparam int          SEC_PER_MIN      = 60;
  localparam int          TIMEOUT_MIN      = 30;
  localparam logic [15:0] TIMEOUT_TICKS    = 16'(TIMEOUT_MIN * SEC_PER_MIN);
  localparam int          COMPOSITE_SHIFT  = 4;
  localparam int          ATTENUATED_SHIFT = 7;

  // ==========================================================================
  // Relay test codes
  localparam logic [2:0] RT_NORMAL = 3'h0;
  localparam logic [2:0] RT_OPEN   = 3'h1;
  localparam logic [2:0] RT_TWO    = 3'h2;
  localparam logic [2:0] RT_THREE  = 3'h3;
  localparam logic [2:0] RT_FOUR   = 3'h4;

  typedef enum logic [1:0] {
    STK_IDLE,
    STK_CLOSING,
    STK_WAIT_OPEN
  } smt_stroke_type;

endpackage

/* File: smt_service_assertions.sv */
// Concurrent checks on the ports of the service test and stroke limit block
`timescale 1ns/1ps
module smt_service_assertions (
  input wire logic       clk_sys,
  input wire logic       rst_b,
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic       stroke_switch_contact_b,
  input wire logic       ctl_valve_open,
  input wire logic       valve_open_relay,
  input wire logic       valve_close_relay,
  input wire logic       burner_stage_one_relay,
  input wire logic       burner_stage_two_relay,
  input wire logic       min_stroke_function_active,
  input wire logic [7:0] warm_point_flow_setpoint,
  input wire logic [7:0] cold_point_flow_setpoint
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  // ==========================================================================
  // Stroke limitation
  a_rise_needs_contact:
    assert property ($rose(min_stroke_function_active) |-> !$past(stroke_switch_contact_b))
    else $error("stroke limit began without a bridged contact");
  a_close_first:
    assert property ($rose(min_stroke_function_active) |=> valve_close_relay [*3])
    else $error("valve not driven closed after stroke limit began");
  // First active cycle may still carry the relays of the trigger cycle
  a_stroke_holds_closed:
    assert property (min_stroke_function_active && $past(min_stroke_function_active)
                     |-> valve_close_relay && !valve_open_relay)
    else $error("valve not held closed under stroke limit");
  a_release_opens:
    assert property ($fell(min_stroke_function_active) && $past(ctl_valve_open)
                     |-> valve_open_relay)
    else $error("opening pulse did not reopen the valve");

  // ==========================================================================
  // Relays, curve and bus
  a_valves_exclusive:
    assert property (!(valve_open_relay && valve_close_relay))
    else $error("both valve relays energized");
  a_stage_two_pairs:
    assert property (burner_stage_two_relay |-> burner_stage_one_relay)
    else $error("burner stage two without stage one");
  a_curve_ordered:
    assert property (warm_point_flow_setpoint <= cold_point_flow_setpoint)
    else $error("warm point setpoint above cold point setpoint");
  a_bus_okay:
    assert property (hreadyout && !hresp)
    else $error("bus slave stalled or answered with an error");
endmodule

bind smt_service_ctrl smt_service_assertions u_chk (
  .clk_sys                    (clk_sys),
  .rst_b                      (rst_b),
  .hreadyout                  (hreadyout),
  .hresp                      (hresp),
  .stroke_switch_contact_b    (stroke_switch_contact_b),
  .ctl_valve_open             (ctl_valve_open),
  .valve_open_relay           (valve_open_relay),
  .valve_close_relay          (valve_close_relay),
  .burner_stage_one_relay     (burner_stage_one_relay),
  .burner_stage_two_relay     (burner_stage_two_relay),
  .min_stroke_function_active (min_stroke_function_active),
  .warm_point_flow_setpoint   (warm_point_flow_setpoint),
  .cold_point_flow_setpoint   (cold_point_flow_setpoint)
);

/* File: smt_service_ctrl.sv */
// Minimum stroke limit, outside temperature simulation and relay test with AHB-Lite registers
`timescale 1ns/1ps
module smt_service_ctrl (
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  // Timing base and keypad
  input  wire logic              tick_sec,
  input  wire logic              key_info,
  input  wire logic              key_mode,
  input  wire logic              key_nav,
  // Actuator and normal control
  input  wire logic              stroke_switch_contact_b,
  input  wire logic              ctl_valve_open,
  input  wire logic              ctl_valve_close,
  input  wire logic              lim_close_request,
  input  wire logic              ctl_burner_one,
  input  wire logic              ctl_burner_two,
  input  wire logic              ctl_pump,
  input  wire logic signed [7:0] outside_temperature_sensed,
  // Relays, temperatures and display
  output logic                   valve_open_relay,
  output logic                   valve_close_relay,
  output logic                   burner_stage_one_relay,
  output logic                   burner_stage_two_relay,
  output logic                   circulating_pump_relay,
  output logic                   min_stroke_function_active,
  output logic signed [7:0]      outside_temperature,
  output logic signed [7:0]      composite_outside_temperature,
  output logic signed [7:0]      attenuated_outside_temperature,
  output logic [7:0]             warm_point_flow_setpoint,
  output logic [7:0]             cold_point_flow_setpoint
);
  import smt_pkg::*;

  // ==========================================================================
  // State
  typedef struct packed {
    logic [7:0]        addr;
    logic              wr_pend;
    logic [31:0]       rdata;
    logic              plant_burner;
    logic [7:0]        close_min;
    logic [2:0]        relay_code;
    logic              sim_on;
    logic signed [7:0] sim_val;
    logic signed [7:0] actual;
    logic [7:0]        curve_base;
    logic [7:0]        curve_slope;
    smt_stroke_type    stk;
    logic              bridged_q;
    logic [4:0]        relays;
    logic [7:0]        warm;
    logic [7:0]        cold;
  } smt_state_type;

  smt_state_type     s_r;
  smt_state_type     s_nxt;

  logic              addr_ok;
  logic              wr_now;
  logic              bridged;
  logic              stroke_en;
  logic              stk_start;
  logic              stk_done;
  logic              sim_start;
  logic              rt_start;
  logic              sim_run;
  logic              sim_exp;
  logic              rt_run;
  logic              rt_exp;
  logic [15:0]       close_ticks;
  logic signed [7:0] wdat_temp;
  logic              v_open;
  logic              v_close;
  logic [10:0]       warm_sum;
  logic [10:0]       cold_sum;
  logic signed [7:0] comp_val;
  logic signed [7:0] att_val;

  // ==========================================================================
  // Timers
  assign close_ticks = 16'(s_r.close_min) * 16'(SEC_PER_MIN);

  smt_tick_timer u_close_timer (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .start   (stk_start),
    .stop    (!stroke_en),
    .tick    (tick_sec),
    .limit   (close_ticks),
    .running (),
    .expired (stk_done)
  );

  smt_tick_timer u_sim_timer (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .start   (sim_start),
    .stop    (!s_nxt.sim_on),
    .tick    (tick_sec),
    .limit   (TIMEOUT_TICKS),
    .running (sim_run),
    .expired (sim_exp)
  );

  smt_tick_timer u_relay_timer (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .start   (rt_start),
    .stop    (s_nxt.relay_code == RT_NORMAL),
    .tick    (tick_sec),
    .limit   (TIMEOUT_TICKS),
    .running (rt_run),
    .expired (rt_exp)
  );

  // ==========================================================================
  // Outside temperature lag filters
  smt_converge #(.SHIFT(COMPOSITE_SHIFT)) u_composite (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .load    (s_r.sim_on),
    .step    (tick_sec),
    .target  (s_r.actual),
    .value   (comp_val)
  );

  smt_converge #(.SHIFT(ATTENUATED_SHIFT)) u_attenuated (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .load    (s_r.sim_on),
    .step    (tick_sec),
    .target  (s_r.actual),
    .value   (att_val)
  );

  // ==========================================================================
  // Next state
  always_comb begin
    s_nxt     = s_r;
    wdat_temp = hwdata[7:0];
    sim_start = 1'b0;
    rt_start  = 1'b0;
    stk_start = 1'b0;
    addr_ok   = hsel && hready && htrans[1];
    wr_now    = s_r.wr_pend;
    bridged   = !stroke_switch_contact_b;
    stroke_en = (s_r.close_min != 8'h00);
    v_open    = 1'b0;
    v_close   = 1'b0;
    warm_sum  = '0;
    cold_sum  = '0;

    // Bus address phase; all transfers complete with no wait state
    if (hready) begin
      s_nxt.wr_pend = addr_ok && hwrite;
      s_nxt.addr    = haddr[7:0];
    end
    if (addr_ok && !hwrite) begin
      case (haddr[7:0])
        ADDR_CONFIG: s_nxt.rdata = {31'h0, s_r.plant_burner};
        ADDR_STROKE: s_nxt.rdata = {24'h0, s_r.close_min};
        ADDR_SIM:    s_nxt.rdata = {23'h0, !s_r.sim_on, s_r.sim_val};
        ADDR_RELAY:  s_nxt.rdata = {29'h0, s_r.relay_code};
        ADDR_CURVE:  s_nxt.rdata = {16'h0, s_r.curve_slope, s_r.curve_base};
        ADDR_STATUS: s_nxt.rdata = {24'h0, s_r.relays, rt_run, sim_run,
                                    (s_r.stk != STK_IDLE)};
        ADDR_TEMPS:  s_nxt.rdata = {8'h0, att_val, comp_val, s_r.actual};
        ADDR_SETPT:  s_nxt.rdata = {16'h0, s_r.cold, s_r.warm};
        default:     s_nxt.rdata = 32'h0;
      endcase
    end

    // Simulation: clears first, so a write in the same cycle wins
    if (key_info || key_mode || sim_exp) begin
      s_nxt.sim_on = 1'b0;
    end
    // Relay test ends the same way and also on the navigation key; timeout drops every forced relay
    if (key_nav || key_info || key_mode || rt_exp) begin
      s_nxt.relay_code = RT_NORMAL;
    end

    // Data phase writes
    if (wr_now) begin
      case (s_r.addr)
        ADDR_CONFIG: s_nxt.plant_burner = hwdata[0];
        ADDR_STROKE: s_nxt.close_min = hwdata[7:0];
        ADDR_SIM: begin
          if (hwdata[SIM_BLANK_BIT]) begin
            s_nxt.sim_on = 1'b0;
          end else if (wdat_temp >= SIM_LOW && wdat_temp <= SIM_HIGH) begin
            s_nxt.sim_on  = 1'b1;
            s_nxt.sim_val = wdat_temp;
            sim_start     = 1'b1;
          end
        end
        ADDR_RELAY: begin
          if (hwdata[2:0] == RT_NORMAL) begin
            s_nxt.relay_code = RT_NORMAL;
          end else if (hwdata[2:0] <= RT_FOUR && hwdata[31:3] == 29'h0) begin
            s_nxt.relay_code = hwdata[2:0];
            rt_start         = 1'b1;
          end
        end
        ADDR_CURVE: begin
          s_nxt.curve_base  = hwdata[7:0];
          s_nxt.curve_slope = hwdata[15:8];
        end
        default: ;
      endcase
    end

    // Simulated value stands in for the sensed one everywhere
    s_nxt.actual = s_nxt.sim_on ? s_nxt.sim_val : outside_temperature_sensed;

    // Minimum stroke sequencer
    s_nxt.bridged_q = bridged;
    case (s_r.stk)
      STK_IDLE: begin
        if (stroke_en && bridged && (!s_r.bridged_q || ctl_valve_open)) begin
          s_nxt.stk = STK_CLOSING;
          stk_start = 1'b1;
        end
      end
      STK_CLOSING: begin
        if (!stroke_en) begin
          s_nxt.stk = STK_IDLE;
        end else if (stk_done) begin
          s_nxt.stk = STK_WAIT_OPEN;
        end
      end
      STK_WAIT_OPEN: begin
        if (!stroke_en || ctl_valve_open) begin
          s_nxt.stk = STK_IDLE;
        end
      end
      default: s_nxt.stk = STK_IDLE;
    endcase

    // Valve drive: stroke limit sits above every other limitation
    if (s_r.stk == STK_CLOSING) begin
      v_close = 1'b1;
    end else if (s_r.stk == STK_WAIT_OPEN) begin
      // The opening pulse itself passes through as it ends the wait
      v_open  = ctl_valve_open;
      v_close = !ctl_valve_open;
    end else begin
      v_open  = ctl_valve_open && !lim_close_request && !ctl_valve_close;
      v_close = ctl_valve_close || lim_close_request;
    end

    // Relay image {valve open, valve close, stage one, stage two, pump}
    case (s_r.relay_code)
      RT_NORMAL: begin
        if (s_r.plant_burner) begin
          s_nxt.relays = {2'b00, ctl_burner_one, ctl_burner_two && ctl_burner_one, ctl_pump};
        end else begin
          s_nxt.relays = {v_open, v_close, 2'b00, ctl_pump};
        end
      end
      RT_OPEN: s_nxt.relays = 5'h00;
      RT_TWO: s_nxt.relays = s_r.plant_burner ? 5'h04 : 5'h10;
      RT_THREE: s_nxt.relays = s_r.plant_burner ? 5'h06 : 5'h08;
      RT_FOUR: s_nxt.relays = 5'h01;
      default: s_nxt.relays = 5'h00;
    endcase

    // Heating curve points; slope is in eighths of a kelvin per kelvin
    warm_sum = 11'(s_r.curve_base) + 11'((14'(s_r.curve_slope) * 14'(WARM_DELTA)) >> SLOPE_FRAC);
    cold_sum = 11'(s_r.curve_base) + 11'((14'(s_r.curve_slope) * 14'(COLD_DELTA)) >> SLOPE_FRAC);
    // Saturate rather than wrap so a steep curve never reads as cold water
    s_nxt.warm = (warm_sum[10:8] != 3'h0) ? 8'hff : warm_sum[7:0];
    s_nxt.cold = (cold_sum[10:8] != 3'h0) ? 8'hff : cold_sum[7:0];
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_r             <= '0;
      s_r.close_min   <= CLOSE_MIN_RST;
      s_r.relay_code  <= RELAY_CODE_RST;
      s_r.curve_base  <= CURVE_BASE_RST;
      s_r.curve_slope <= CURVE_SLOPE_RST;
      s_r.stk         <= STK_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  assign hreadyout                      = 1'b1;
  assign hresp                          = 1'b0;
  assign hrdata                         = s_r.rdata;
  assign valve_open_relay               = s_r.relays[4];
  assign valve_close_relay              = s_r.relays[3];
  assign burner_stage_one_relay         = s_r.relays[2];
  assign burner_stage_two_relay         = s_r.relays[1];
  assign circulating_pump_relay         = s_r.relays[0];
  assign min_stroke_function_active     = (s_r.stk != STK_IDLE);
  assign outside_temperature            = s_r.actual;
  assign composite_outside_temperature  = comp_val;
  assign attenuated_outside_temperature = att_val;
  assign warm_point_flow_setpoint       = s_r.warm;
  assign cold_point_flow_setpoint       = s_r.cold;
endmodule

/* File: smt_tick_timer.sv */
// Down-counter of system ticks with restart, stop and a one-cycle expiry pulse
`timescale 1ns/1ps
module smt_tick_timer (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        start,
  input  wire logic        stop,
  input  wire logic        tick,
  input  wire logic [15:0] limit,
  output logic             running,
  output logic             expired
);
  import smt_pkg::*;

  typedef struct packed {
    logic [15:0] cnt;
    logic        run;
    logic        exp;
  } smt_timer_type;

  smt_timer_type s_r;
  smt_timer_type s_nxt;

  always_comb begin
    s_nxt     = s_r;
    s_nxt.exp = 1'b0;
    if (start) begin
      // Restart always wins over a tick in the same cycle
      s_nxt.cnt = limit;
      s_nxt.run = (limit != 16'h0000);
    end else if (stop) begin
      s_nxt.run = 1'b0;
    end else if (s_r.run && tick) begin
      s_nxt.cnt = s_r.cnt - 16'h0001;
      if (s_r.cnt == 16'h0001) begin
        s_nxt.run = 1'b0;
        s_nxt.exp = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign running = s_r.run;
  assign expired = s_r.exp;
endmodule

/* File: smt_valve_model.sv */
// Valve actuator with auxiliary stroke switch, driven by the valve relays
`timescale 1ns/1ps
module smt_valve_model #(
  parameter int MIN_POS = 3
) (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic valve_open_relay,
  input  wire logic valve_close_relay,
  output logic      stroke_switch_contact_b
);
  // ==========================================================================
  // Stroke position, one step per cycle
  logic [3:0] pos_r;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pos_r <= 4'hf;
    end else if (valve_open_relay && pos_r != 4'hf) begin
      pos_r <= pos_r + 4'h1;
    end else if (valve_close_relay && pos_r != 4'h0) begin
      pos_r <= pos_r - 4'h1;
    end
  end

  // Switch bridges to ground below the minimum-flow stroke
  assign stroke_switch_contact_b = (pos_r >= 4'(MIN_POS));
endmodule

/* File: tb_smt_service_ctrl.sv */
// Self-checking bench for the service test and stroke limit block
`timescale 1ns/1ps
module tb_smt_service_ctrl;
  import smt_pkg::*;
  logic               clk_sys, rst_b, hsel, hwrite, hreadyout, hresp, tick_sec;
  logic               key_info, key_mode, key_nav, lim_close_request, ctl_pump;
  logic               ctl_valve_open, ctl_valve_close, ctl_burner_one, ctl_burner_two;
  logic               valve_open_relay, valve_close_relay, burner_stage_one_relay;
  logic               burner_stage_two_relay, circulating_pump_relay;
  logic               min_stroke_function_active, stroke_switch_contact_b;
  logic [31:0]        haddr, hwdata, hrdata;
  logic [1:0]         htrans;
  logic [2:0]         hsize;
  logic signed [7:0]  outside_temperature_sensed, outside_temperature;
  logic signed [7:0]  composite_outside_temperature, attenuated_outside_temperature;
  logic [7:0]         warm_point_flow_setpoint, cold_point_flow_setpoint;
  int                 err_total, n_checks;
  logic               seen;
  wire logic [4:0]    relays = {valve_open_relay, valve_close_relay, burner_stage_one_relay,
                                burner_stage_two_relay, circulating_pump_relay};
  wire logic [23:0]   temps = {attenuated_outside_temperature, composite_outside_temperature,
                               outside_temperature};
  // Relay pattern per plant (valve, burner) and test code, pump requested by control
  localparam logic [4:0] RT_EXP [2][5] = '{'{5'h01, 5'h00, 5'h10, 5'h08, 5'h01},
                                           '{5'h01, 5'h00, 5'h04, 5'h06, 5'h01}};

  smt_service_ctrl dut (
    .clk_sys, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .tick_sec, .key_info, .key_mode,
    .key_nav, .stroke_switch_contact_b, .ctl_valve_open, .ctl_valve_close,
    .lim_close_request, .ctl_burner_one, .ctl_burner_two, .ctl_pump,
    .outside_temperature_sensed, .valve_open_relay, .valve_close_relay,
    .burner_stage_one_relay, .burner_stage_two_relay, .circulating_pump_relay,
    .min_stroke_function_active, .outside_temperature, .composite_outside_temperature,
    .attenuated_outside_temperature, .warm_point_flow_setpoint, .cold_point_flow_setpoint
  );

  smt_valve_model u_valve (
    .clk_sys, .rst_b, .valve_open_relay, .valve_close_relay, .stroke_switch_contact_b
  );

  // ==========================================================================
  // Clock and a one-second tick every other cycle to keep minute counts short
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) tick_sec <= rst_b & ~tick_sec;

  // ==========================================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    bus(1'b1, a, d, v);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    chk(v, e);
  endtask

  // Keys as {navigation, info, mode}
  task automatic press(input logic [2:0] k);
    {key_nav, key_info, key_mode} <= k;
    cyc(1);
    {key_nav, key_info, key_mode} <= 3'h0;
    cyc(2);
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    cyc(20000);
    err_total++;
    close_out();
  end

  // ==========================================================================
  // Tests
  initial begin
    {hsel, hwrite, key_info, key_mode, key_nav, ctl_valve_open, ctl_valve_close} = '0;
    {lim_close_request, ctl_burner_one, ctl_burner_two, ctl_pump} = '0;
    {haddr, hwdata, htrans} = '0;
    hsize = 3'h2;
    outside_temperature_sensed = 8'sd10;
    rst_b = 1'b0;
    err_total = 0;
    n_checks = 0;
    cyc(8);
    rst_b <= 1'b1;
    cyc(1);
    rdc(ADDR_STROKE, 32'h6);
    rdc(ADDR_RELAY, 32'h0);
    rdc(ADDR_SIM, 32'h100);
    rdc(ADDR_STATUS, 32'h0);
    rdc(ADDR_SETPT, 32'h4325);
    wr(8'h20, 32'hffff_ffff);
    rdc(8'h20, 32'h0);
    chk(32'(outside_temperature), 32'h0a);
    $display("test reset done");

    // Close the valve until the switch bridges, factory closing time
    ctl_valve_close <= 1'b1;
    repeat (100) if (min_stroke_function_active !== 1'b1) @(posedge clk_sys);
    ctl_valve_close <= 1'b0;
    cyc(2);
    chk(32'(relays), 32'h08);
    rdc(ADDR_STATUS, 32'h41);
    cyc(300);
    ctl_valve_open <= 1'b1;
    cyc(1);
    ctl_valve_open <= 1'b0;
    cyc(3);
    chk(32'({relays, min_stroke_function_active}), 32'h11);
    cyc(500);
    chk(32'({relays, min_stroke_function_active}), 32'h11);
    ctl_valve_open <= 1'b1;
    cyc(1);
    ctl_valve_open <= 1'b0;
    seen = 1'b0;
    repeat (3) begin
      @(posedge clk_sys);
      seen |= valve_open_relay;
    end
    chk(32'(seen), 32'h1);
    chk(32'(min_stroke_function_active), 32'h0);
    $display("test stroke done");

    // Stroke limit off so relay-driven valve travel cannot trigger it
    wr(ADDR_STROKE, 32'h0);
    ctl_pump <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      wr(ADDR_CONFIG, 32'(p));
      for (int c = 0; c < 5; c++) begin
        wr(ADDR_RELAY, 32'(c));
        cyc(2);
        chk(32'(relays), 32'(RT_EXP[p][c]));
        rdc(ADDR_STATUS, {24'h0, RT_EXP[p][c], c != 0, 2'b00});
      end
    end
    wr(ADDR_RELAY, 32'h5);
    rdc(ADDR_RELAY, 32'h4);
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_RELAY, 32'h2);
      press(3'b001 << k);
      rdc(ADDR_RELAY, 32'h0);
    end
    wr(ADDR_CONFIG, 32'h0);
    wr(ADDR_CURVE, 32'hc81e);
    cyc(2);
    rdc(ADDR_SETPT, 32'hff9b);
    chk(32'({cold_point_flow_setpoint, warm_point_flow_setpoint}), 32'hff9b);
    $display("test relay done");

    wr(ADDR_SIM, 32'hce);
    cyc(2);
    chk(32'(temps), 32'hcecece);
    wr(ADDR_SIM, 32'h33);
    wr(ADDR_SIM, 32'hcd);
    cyc(2);
    chk(32'(temps), 32'hcecece);
    wr(ADDR_SIM, 32'h32);
    cyc(2);
    chk(32'(temps), 32'h323232);
    outside_temperature_sensed <= -8'sd20;
    press(3'b010);
    cyc(40);
    chk(32'(outside_temperature), 32'hffff_ffec);
    chk(32'(composite_outside_temperature > -8'sd20 &&
            composite_outside_temperature < 8'sd50), 32'h1);
    chk(32'(attenuated_outside_temperature > composite_outside_temperature &&
            attenuated_outside_temperature < 8'sd50), 32'h1);
    rdc(ADDR_STATUS, 32'h08);
    wr(ADDR_SIM, 32'h0);
    wr(ADDR_SIM, 32'h100);
    rdc(ADDR_STATUS, 32'h08);
    wr(ADDR_SIM, 32'h5);
    press(3'b100);
    rdc(ADDR_STATUS, 32'h0a);
    press(3'b001);
    rdc(ADDR_STATUS, 32'h08);
    $display("test simulation done");

    // Restart both timeouts midway; the first start alone would have expired
    wr(ADDR_SIM, 32'h5);
    wr(ADDR_RELAY, 32'h1);
    cyc(2000);
    wr(ADDR_SIM, 32'h7);
    wr(ADDR_RELAY, 32'h1);
    cyc(2400);
    rdc(ADDR_STATUS, 32'h06);
    cyc(1400);
    rdc(ADDR_STATUS, 32'h08);
    rdc(ADDR_RELAY, 32'h0);
    $display("test timeout done");
    close_out();
  end
endmodule
